// ---- pkg/dps_regs.vh ----
// Constants for the dual-slot power select serial control block
`ifndef DPS_REGS_VH
`define DPS_REGS_VH
`define DPS_WORD_W        9
`define DPS_BIT_PA0       0
`define DPS_BIT_PA1       1
`define DPS_BIT_CA_LO     2
`define DPS_BIT_CA_HI     3
`define DPS_BIT_PB0       4
`define DPS_BIT_PB1       5
`define DPS_BIT_CB0       6
`define DPS_BIT_CB1       7
`define DPS_BIT_RUN       8
`define DPS_WORD_RESET    9'h000
`define DPS_SYNC_STAGES   2
// Card supply states (3-bit code on outputs)
`define DPS_CS_HIZ        3'h0
`define DPS_CS_GND        3'h1
`define DPS_CS_3V3        3'h2
`define DPS_CS_5V         3'h3
// Program supply states
`define DPS_PS_HIZ        3'h0
`define DPS_PS_GND        3'h1
`define DPS_PS_CARD       3'h2
`define DPS_PS_12V        3'h3
`endif

// ---- rtl/dps_sync.v ----
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module dps_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Data
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clk_sys) begin
        if (rst) begin
            stage1  <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // dps_sync
`default_nettype wire

// ---- rtl/dps_edge.v ----
// Rising edge detector on a synchronised level
`timescale 1ns/100ps
`default_nettype none
module dps_edge (
    // Clock and reset
    input  wire clk_sys,
    input  wire rst,
    // Level in, pulse out
    input  wire level,
    output wire rise
);
    reg last;

    always @(posedge clk_sys) begin
        if (rst) begin
            last <= 1'b0;
        end else begin
            last <= level;
        end
    end

    assign rise = level & ~last;
endmodule // dps_edge
`default_nettype wire

// ---- rtl/dps_power_select.v ----
// Serial power select control: shift, latch and decode
`timescale 1ns/100ps
`default_nettype none
`include "dps_regs.vh"
module dps_power_select #(
    parameter WORD_W = `DPS_WORD_W
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // Serial link from controller
    input  wire       serialData,
    input  wire       serialClock,
    input  wire       serialLatch,
    // Device pins
    input  wire       reset_n,
    input  wire       power_down_n,
    // Fault inputs, one per output: A card, A prog, B card, B prog
    input  wire [3:0] faultIn,
    // Decoded supply selections
    output reg  [2:0] slot_a_card_supply,
    output reg  [2:0] slot_b_card_supply,
    output reg  [2:0] slot_a_program_supply,
    output reg  [2:0] slot_b_program_supply,
    output reg        overcurrent_flag_n
);
    // Synchronised pins
    wire              clkS;
    wire              dataS;
    wire              latchS;
    wire              resetS_n;
    wire              pdS_n;
    wire [3:0]        faultS;
    // Link events
    wire              clkRise;
    wire              latchRise;
    // Shift and holding registers
    reg  [WORD_W-1:0] shiftWord;
    reg  [WORD_W-1:0] power_select_word;
    reg               grounded;
    // Fields of the holding register
    wire [1:0]        aProgCode;
    wire [1:0]        bProgCode;
    wire [1:0]        aCardCode;
    wire [1:0]        bCardCode;
    wire              runBit;
    wire              shutdown;
    wire              anyFault;
    // Next values of the registered outputs
    reg  [2:0]        next_aCard;
    reg  [2:0]        next_bCard;
    reg  [2:0]        next_aProg;
    reg  [2:0]        next_bProg;
    reg               next_flagN;

    // Every pin passes the same two stages, so data and clock stay aligned
    dps_sync #(
        .WIDTH (1)
    ) uSyncClk (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (serialClock),
        .syncOut (clkS)
    );

    dps_sync #(
        .WIDTH (1)
    ) uSyncD (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (serialData),
        .syncOut (dataS)
    );

    dps_sync #(
        .WIDTH (1)
    ) uSyncLatch (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (serialLatch),
        .syncOut (latchS)
    );

    dps_sync #(
        .WIDTH (1)
    ) uSyncRst (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (reset_n),
        .syncOut (resetS_n)
    );

    dps_sync #(
        .WIDTH (1)
    ) uSyncPd (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (power_down_n),
        .syncOut (pdS_n)
    );

    // Faults: A card, A prog, B card, B prog
    dps_sync #(
        .WIDTH (4)
    ) uSyncFault (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (faultIn),
        .syncOut (faultS)
    );

    // Edges of the synchronised link clock and latch
    dps_edge uClkEdge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (clkS),
        .rise    (clkRise)
    );

    dps_edge uLatchEdge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (latchS),
        .rise    (latchRise)
    );

    // Each pair except A card is read with its first-named bit as the high bit; A card takes its HI bit as the high bit
    assign aProgCode = {power_select_word[`DPS_BIT_PA0],
                        power_select_word[`DPS_BIT_PA1]};
    assign bProgCode = {power_select_word[`DPS_BIT_PB0],
                        power_select_word[`DPS_BIT_PB1]};
    assign aCardCode = {power_select_word[`DPS_BIT_CA_HI],
                        power_select_word[`DPS_BIT_CA_LO]};
    assign bCardCode = {power_select_word[`DPS_BIT_CB0],
                        power_select_word[`DPS_BIT_CB1]};
    assign runBit    = power_select_word[`DPS_BIT_RUN];

    // Pin shutdown acts at once; it is not latched into the word
    assign shutdown  = ~runBit | ~pdS_n;
    assign anyFault  = |faultS;

    // Card supply code: both 00 and 11 ground the output
    function [2:0] cardDecode;
        input [1:0] code;
        begin
            case (code)
                2'h1:    cardDecode = `DPS_CS_3V3;
                2'h2:    cardDecode = `DPS_CS_5V;
                default: cardDecode = `DPS_CS_GND;
            endcase
        end
    endfunction

    // Program supply code: 11 leaves the output open
    function [2:0] progDecode;
        input [1:0] code;
        begin
            case (code)
                2'h0:    progDecode = `DPS_PS_GND;
                2'h1:    progDecode = `DPS_PS_CARD;
                2'h2:    progDecode = `DPS_PS_12V;
                default: progDecode = `DPS_PS_HIZ;
            endcase
        end
    endfunction

    // Shift in; a longer stream pushes old bits out the top
    always @(posedge clk_sys) begin
        if (rst) begin
            shiftWord <= {WORD_W{1'b0}};
        end else if (clkRise) begin
            shiftWord <= {shiftWord[WORD_W-2:0], dataS};
        end
    end

    // First bit sent ends up in bit 8, last in bit 0
    always @(posedge clk_sys) begin
        if (rst) begin
            power_select_word <= `DPS_WORD_RESET;
        end else if (resetS_n && latchRise) begin
            power_select_word <= shiftWord;
        end
    end

    // A latch seen while the pin reset is low is dropped
    always @(posedge clk_sys) begin
        if (rst) begin
            grounded <= 1'b1;
        end else if (!resetS_n) begin
            grounded <= 1'b1;
        end else if (latchRise) begin
            grounded <= 1'b0;
        end
    end

    // Slot A card supply
    always @* begin
        next_aCard = cardDecode(aCardCode);
        if (grounded) begin
            next_aCard = `DPS_CS_GND;
        end else if (shutdown) begin
            next_aCard = `DPS_CS_HIZ;
        end
    end

    // Slot B card supply
    always @* begin
        next_bCard = cardDecode(bCardCode);
        if (grounded) begin
            next_bCard = `DPS_CS_GND;
        end else if (shutdown) begin
            next_bCard = `DPS_CS_HIZ;
        end
    end

    // Slot A program supply
    always @* begin
        next_aProg = progDecode(aProgCode);
        if (grounded) begin
            next_aProg = `DPS_PS_GND;
        end else if (shutdown) begin
            next_aProg = `DPS_PS_HIZ;
        end
    end

    // Slot B program supply
    always @* begin
        next_bProg = progDecode(bProgCode);
        if (grounded) begin
            next_bProg = `DPS_PS_GND;
        end else if (shutdown) begin
            next_bProg = `DPS_PS_HIZ;
        end
    end

    // Flag is low while any output reports a fault
    always @* begin
        next_flagN = ~anyFault;
    end

    // Slot A card supply output
    always @(posedge clk_sys) begin
        if (rst) begin
            slot_a_card_supply <= `DPS_CS_GND;
        end else begin
            slot_a_card_supply <= next_aCard;
        end
    end

    // Slot B card supply output
    always @(posedge clk_sys) begin
        if (rst) begin
            slot_b_card_supply <= `DPS_CS_GND;
        end else begin
            slot_b_card_supply <= next_bCard;
        end
    end

    // Slot A program supply output
    always @(posedge clk_sys) begin
        if (rst) begin
            slot_a_program_supply <= `DPS_PS_GND;
        end else begin
            slot_a_program_supply <= next_aProg;
        end
    end

    // Slot B program supply output
    always @(posedge clk_sys) begin
        if (rst) begin
            slot_b_program_supply <= `DPS_PS_GND;
        end else begin
            slot_b_program_supply <= next_bProg;
        end
    end

    // Overcurrent flag output
    always @(posedge clk_sys) begin
        if (rst) begin
            overcurrent_flag_n <= 1'b1;
        end else begin
            overcurrent_flag_n <= next_flagN;
        end
    end
endmodule // dps_power_select
`default_nettype wire

// ---- dv/dps_power_select_properties.sv ----
// Port-level checks for the power select block
`timescale 1ns/100ps
`default_nettype none
module dps_power_select_properties #(
    parameter WORD_W = 9
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Serial link and pins
    input wire logic       serialData,
    input wire logic       serialClock,
    input wire logic       serialLatch,
    input wire logic       reset_n,
    input wire logic       power_down_n,
    input wire logic [3:0] faultIn,
    // Supply selections and flag
    input wire logic [2:0] slot_a_card_supply,
    input wire logic [2:0] slot_b_card_supply,
    input wire logic [2:0] slot_a_program_supply,
    input wire logic [2:0] slot_b_program_supply,
    input wire logic       overcurrent_flag_n
);
    wire [11:0] outs = {slot_a_card_supply, slot_b_card_supply,
                        slot_a_program_supply, slot_b_program_supply};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rstGnd; $fell(rst) |-> outs == 12'h249; endproperty
    a_rstGnd: assert property (p_rstGnd) else $error("not grounded");
    property p_pinGnd;
        (!reset_n && power_down_n) [*5] |-> outs == 12'h249;
    endproperty
    a_pinGnd: assert property (p_pinGnd) else $error("pin reset");
    property p_pwrDown;
        (!power_down_n && reset_n) [*5] |-> outs == 12'h000;
    endproperty
    a_pwrDown: assert property (p_pwrDown) else $error("shutdown");
    property p_flagOn; (faultIn != 4'h0) [*4] |-> !overcurrent_flag_n; endproperty
    a_flagOn: assert property (p_flagOn) else $error("flag missing");
    property p_flagOff; (faultIn == 4'h0) [*4] |-> overcurrent_flag_n; endproperty
    a_flagOff: assert property (p_flagOff) else $error("flag stuck");
    // Wide window: latch pin rise needs about four cycles to reach outputs
    property p_hold;
        $stable({serialLatch, reset_n, power_down_n}) [*8] |-> $stable(outs);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved");
    property p_aHiz;
        slot_a_card_supply == 3'h0 |-> slot_a_program_supply == 3'h0;
    endproperty
    a_aHiz: assert property (p_aHiz) else $error("slot a hiz");
    property p_bHiz;
        slot_b_card_supply == 3'h0 |-> slot_b_program_supply == 3'h0;
    endproperty
    a_bHiz: assert property (p_bHiz) else $error("slot b hiz");
endmodule // dps_power_select_properties
bind dps_power_select dps_power_select_properties #(.WORD_W(WORD_W)) chk (
    .clk_sys(clk_sys), .rst(rst), .serialData(serialData),
    .serialClock(serialClock), .serialLatch(serialLatch), .reset_n(reset_n),
    .power_down_n(power_down_n), .faultIn(faultIn),
    .slot_a_card_supply(slot_a_card_supply),
    .slot_b_card_supply(slot_b_card_supply),
    .slot_a_program_supply(slot_a_program_supply),
    .slot_b_program_supply(slot_b_program_supply),
    .overcurrent_flag_n(overcurrent_flag_n));
`default_nettype wire

// ---- dv/dps_host_model.sv ----
// Controller side of the serial power select link
`timescale 1ns/100ps
`default_nettype none
module dps_host_model (
    // Serial link
    output logic serialData,
    output logic serialClock,
    output logic serialLatch
);
    initial begin
        serialData = 1'b0;
        serialClock = 1'b0;
        serialLatch = 1'b0;
    end
    // Highest bit first; clock idles low between frames
    task automatic send(input [10:0] w, input int n, input real hp,
                        input bit lat);
        // Off the system clock grid, so no pin moves on a sampling edge
        #(1.25);
        for (int i = n - 1; i >= 0; i--) begin
            serialData = w[i];
            #(hp) serialClock = 1'b1;
            #(hp) serialClock = 1'b0;
        end
        #(hp / 2) serialLatch = lat;
        #(hp) serialLatch = 1'b0;
        // Released line must not keep a stale value
        serialData = ~serialData;
    endtask
endmodule // dps_host_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the power select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic       clk_sys = 1'b0, rst = 1'b1, reset_n = 1'b1, power_down_n = 1'b1;
    logic [3:0] faultIn = 4'h0;
    logic [2:0] cardA, cardB, progA, progB;
    logic       ocN;
    wire        serialData, serialClock, serialLatch;
    int         miscompares = 0, numChecks = 0, cycles = 0;
    wire [11:0] outs = {cardA, cardB, progA, progB};
    always #5 clk_sys = ~clk_sys;
    dps_host_model ctl (.serialData(serialData), .serialClock(serialClock),
        .serialLatch(serialLatch));
    dps_power_select uut (.clk_sys(clk_sys), .rst(rst), .serialData(serialData),
        .serialClock(serialClock), .serialLatch(serialLatch), .reset_n(reset_n),
        .power_down_n(power_down_n), .faultIn(faultIn),
        .slot_a_card_supply(cardA), .slot_b_card_supply(cardB),
        .slot_a_program_supply(progA), .slot_b_program_supply(progB),
        .overcurrent_flag_n(ocN));
    function automatic [2:0] card(input [1:0] c);
        return c == 2'b01 ? 3'h2 : c == 2'b10 ? 3'h3 : 3'h1;
    endfunction
    function automatic [2:0] prog(input [1:0] c);
        return c == 2'b11 ? 3'h0 : 3'h1 + {1'b0, c};
    endfunction
    function automatic [11:0] expOf(input [8:0] w);
        if (!w[8])
            return 12'h000;
        return {card({w[3], w[2]}), card({w[6], w[7]}),
                prog({w[0], w[1]}), prog({w[4], w[5]})};
    endfunction
    task automatic waitChk(input [11:0] e);
        repeat (8) @(negedge clk_sys);
        `CHK(outs, e)
    endtask
    task automatic conclude;
        if (miscompares == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        logic [8:0] w;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        waitChk(12'h249);
        for (int c = 0; c < 4; c++) begin
            w = {1'b1, c[0], c[1], c[0], c[1], c[1], c[0], c[0], c[1]};
            ctl.send({2'b00, w}, 9, 62.5, 1'b1);
            waitChk(expOf(w));
        end
        ctl.send(11'h6B5, 11, 62.5, 1'b1);
        waitChk(12'h000);
        ctl.send(11'h5C6, 11, 62.5, 1'b1);
        waitChk(expOf(9'h1C6));
        ctl.send(11'h039, 9, 62.5, 1'b0);
        waitChk(expOf(9'h1C6));
        power_down_n = 1'b0;
        waitChk(12'h000);
        power_down_n = 1'b1;
        waitChk(expOf(9'h1C6));
        reset_n = 1'b0;
        waitChk(12'h249);
        ctl.send(11'h1A5, 9, 62.5, 1'b1);
        @(negedge clk_sys);
        reset_n = 1'b1;
        waitChk(12'h249);
        ctl.send(11'h1A5, 9, 62.5, 1'b1);
        waitChk(expOf(9'h1A5));
        for (int i = 0; i < 4; i++) begin
            faultIn = 4'h1 << i;
            repeat (8) @(negedge clk_sys);
            `CHK(ocN, 1'b0)
            faultIn = 4'h0;
            repeat (8) @(negedge clk_sys);
            `CHK(ocN, 1'b1)
        end
        conclude();
    end
endmodule // tb
`default_nettype wire
